// [rtl/hos_pkg.sv]
// Shared constants and types for the harmonic overcurrent stage.
package hos_pkg;
  localparam int STAGES = 4;
  localparam int CHANS = 5;
  localparam int HARMS = 12;
  localparam int MAGW = 16;
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int RESET_PCT = 97;
  localparam int PCT_FULL = 100;
  localparam int PCT_SCALE = 10000;
  localparam int RATIO_MAX = 10000000;
  localparam int TIME_MAX_MS = 1800000;
  localparam int TIME_STEP_MS = 5;
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int HIST_LEN = PRE_FAULT_MS / PRE_TRIG_MS;
  localparam int LOG_LEN = 12;
  localparam logic [3:0] HARM_DEF = 4'h0;
  localparam logic [15:0] THR_PU_DEF = 16'h0014;
  localparam logic [15:0] THR_PU_MIN = 16'h0005;
  localparam logic [15:0] THR_PU_MAX = 16'h00c8;
  localparam logic [15:0] THR_PCT_DEF = 16'h07d0;
  localparam logic [15:0] THR_PCT_MIN = 16'h01f4;
  localparam logic [15:0] THR_PCT_MAX = 16'h4e20;
  localparam logic [1:0] IN_PHASES = 2'h0;
  localparam logic [1:0] IN_RES1 = 2'h1;
  localparam logic [1:0] IN_RES2 = 2'h2;
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam int CNT_START = 0;
  localparam int CNT_TRIP = 1;
  localparam int CNT_BLOCKED = 2;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'b00001,
    ST_START = 5'b00010,
    ST_TRIP = 5'b00100,
    ST_BLOCKED = 5'b01000,
    ST_RELEASE = 5'b10000
  } hos_state_t;

  // Event select bits: 0 start on, 1 start off, 2 trip on, 3 trip off, 4 block on, 5 block off.
  typedef struct packed {
    logic [3:0] harm_sel;
    logic pct_mode;
    logic [1:0] in_sel;
    logic [15:0] thr_pu;
    logic [15:0] thr_pct;
    logic inverse_delay_mode;
    logic [20:0] delay_ms;
    logic [20:0] min_ms;
    logic rel_inverse_delay_mode;
    logic [20:0] release_ms;
    logic [1:0] force_to;
    logic [5:0] ev_sel;
  } hos_cfg_t;

  typedef struct packed {
    logic [5:0] flags;
    logic [31:0] stamp;
  } hos_evt_t;

  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0] stage;
    logic [1:0] event_code;
    logic [2:0] fault;
    logic [31:0] pre_trig;
    logic [31:0] fault_cur;
    logic [31:0] pre_fault;
    logic [20:0] remain_ms;
    logic [2:0] group;
  } hos_rec_t;
endpackage

// [rtl/hos_harmonic_overcurrent_stage.sv]
// Harmonic overcurrent protection stages with events, counters and fault log.
`timescale 1ns/1ps
module hos_harmonic_overcurrent_stage
  import hos_pkg::*;
#(
  parameter int N_STG = STAGES,
  parameter int N_LOG = LOG_LEN,
  parameter int MS_CYC = CYC_PER_MS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cycle_tick,
  input wire logic [MAGW-1:0] fft_mag [CHANS][HARMS+1],
  input wire hos_cfg_t cfg [N_STG],
  input wire logic [N_STG-1:0] block_in,
  input wire logic force_enable,
  input wire logic [2:0] setting_group,
  input wire logic [N_STG-1:0] count_clear,
  input wire logic [3:0] log_sel,
  output logic [1:0] cond [N_STG],
  output logic [N_STG-1:0] start_out,
  output logic [N_STG-1:0] trip_out,
  output logic [N_STG-1:0] blocked_out,
  output logic [23:0] ratio [N_STG],
  output logic signed [19:0] time_left [N_STG],
  output logic [19:0] time_expected [N_STG],
  output logic [15:0] counts [N_STG][3],
  output hos_evt_t events [N_STG],
  output hos_rec_t log_rec,
  output logic [3:0] log_newest,
  output logic [4:0] log_count
);

  if (N_STG < 1 || N_STG > 4 || N_LOG < 1 || N_LOG > 16 || MS_CYC < 2 || MS_CYC > 16384) begin : g_bad
    $error("hos: parameter out of range");
  end

  logic [13:0] ms_div;
  logic ms_tick;
  logic [31:0] stamp;
  logic [4:0] h_div;
  wire ms_wrap = ms_div == 14'(MS_CYC - 1);
  wire hist_wrap = h_div == 5'(PRE_TRIG_MS - 1);
  wire hist_tick = ms_tick && hist_wrap;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ms_div <= 14'h0;
      ms_tick <= 1'b0;
      stamp <= 32'h0;
      h_div <= 5'h0;
    end else begin
      ms_div <= ms_wrap ? 14'h0 : ms_div + 14'h1;
      ms_tick <= ms_wrap;
      if (ms_tick) begin
        stamp <= stamp + 32'h1;
        h_div <= hist_wrap ? 5'h0 : h_div + 5'h1;
      end
    end
  end

  logic [2:0] on_ev [N_STG];
  logic [31:0] mx_a [N_STG];
  logic [2:0] fmask_a [N_STG];
  logic [31:0] pretrig_a [N_STG];
  logic [31:0] prefault_a [N_STG];
  logic [20:0] remain_a [N_STG];

  for (genvar s = 0; s < N_STG; s++) begin : g_stg
    logic [31:0] val [CHANS];
    logic [CHANS-1:0] en;
    logic [CHANS-1:0] over;
    logic [CHANS-1:0] under;
    logic [3:0] hidx;
    logic [15:0] thr_raw;
    logic [15:0] thr;
    logic [15:0] tmin;
    logic [15:0] tmax;
    logic [31:0] mx;
    logic pu;
    logic [20:0] el;
    logic [20:0] rc;
    logic [31:0] pf;
    logic [31:0] hist [HIST_LEN];
    hos_state_t st;
    hos_state_t next_st;
    hos_state_t fst;

    // Settings are read live every cycle, so a group change acts at once.
    assign hidx = (cfg[s].harm_sel < 4'(HARMS)) ? cfg[s].harm_sel + 4'h1 : 4'h1;
    assign thr_raw = cfg[s].pct_mode ? cfg[s].thr_pct : cfg[s].thr_pu;
    assign tmin = cfg[s].pct_mode ? THR_PCT_MIN : THR_PU_MIN;
    assign tmax = cfg[s].pct_mode ? THR_PCT_MAX : THR_PU_MAX;
    assign thr = thr_raw < tmin ? tmin : (thr_raw > tmax ? tmax : thr_raw);

    for (genvar c = 0; c < CHANS; c++) begin : g_ch
      wire [MAGW-1:0] h = fft_mag[c][hidx];
      wire [MAGW-1:0] f = fft_mag[c][0];
      // A dead fundamental saturates the percentage rather than dividing by zero.
      assign val[c] = !cfg[s].pct_mode ? 32'(h) :
                      (f == '0) ? 32'hffffffff : (32'(h) * 32'(PCT_SCALE)) / 32'(f);
      assign en[c] = (cfg[s].in_sel == IN_PHASES) ? (c < 3) :
                     (cfg[s].in_sel == IN_RES1) ? (c == 3) : (c == 4);
      assign over[c] = en[c] && val[c] > 32'(thr);
      assign under[c] = !en[c] || 40'(val[c]) * 40'(PCT_FULL) < 40'(thr) * 40'(RESET_PCT);
    end

    always_comb begin
      mx = 32'h0;
      for (int c = 0; c < CHANS; c++) begin
        if (en[c] && val[c] > mx) begin
          mx = val[c];
        end
      end
    end

    wire next_pu = (|over) || (pu && !(&under));
    wire [31:0] ex = mx - 32'(thr);
    wire [47:0] inv = (mx > 32'(thr)) ? 48'(cfg[s].delay_ms) * 48'(thr) / 48'(ex) : 48'(TIME_MAX_MS);
    wire [20:0] inv_c = inv > 48'(TIME_MAX_MS) ? 21'(TIME_MAX_MS) :
                        inv < 48'(cfg[s].min_ms) ? cfg[s].min_ms : inv[20:0];
    wire [20:0] ot = cfg[s].inverse_delay_mode ? inv_c : cfg[s].delay_ms;
    wire [15:0] mxc = mx > 32'(thr) ? thr : mx[15:0];
    wire [36:0] rinv = 37'(cfg[s].release_ms) * 37'(thr - mxc) / 37'(thr);
    wire [20:0] rel_t = cfg[s].rel_inverse_delay_mode ? rinv[20:0] : cfg[s].release_ms;
    wire signed [21:0] rem = $signed({1'b0, ot}) - $signed({1'b0, el});
    wire [47:0] rt = 48'(mx) * 48'(PCT_FULL) / 48'(thr);
    wire [2:0] fl = {st == ST_BLOCKED, st == ST_TRIP, st == ST_START};
    wire [2:0] prev = {blocked_out[s], trip_out[s], start_out[s]};
    wire [2:0] on = fl & ~prev;
    wire [2:0] off = ~fl & prev;

    assign fst = (cfg[s].force_to == COND_START) ? ST_START :
                 (cfg[s].force_to == COND_TRIP) ? ST_TRIP :
                 (cfg[s].force_to == COND_BLOCKED) ? ST_BLOCKED : ST_NORMAL;

    always_comb begin
      next_st = st;
      case (st)
        ST_NORMAL: begin
          if (next_pu) begin
            next_st = block_in[s] ? ST_BLOCKED : ST_START;
          end
        end
        ST_START: begin
          if (block_in[s] || !next_pu) begin
            next_st = ST_RELEASE;
          end else if (el >= ot) begin
            next_st = ST_TRIP;
          end
        end
        ST_RELEASE: begin
          if (next_pu && !block_in[s]) begin
            next_st = ST_START;
          end else if (rc >= rel_t) begin
            next_st = next_pu ? ST_BLOCKED : ST_NORMAL;
          end
        end
        ST_TRIP: begin
          if (!next_pu) begin
            next_st = ST_NORMAL;
          end
        end
        ST_BLOCKED: begin
          if (!next_pu) begin
            next_st = ST_NORMAL;
          end else if (!block_in[s]) begin
            next_st = ST_START;
          end
        end
        default: next_st = ST_NORMAL;
      endcase
      if (force_enable) begin
        next_st = fst;
      end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        st <= ST_NORMAL;
        pu <= 1'b0;
      end else if (cycle_tick) begin
        // Blocking is read only on tick edges, which is its one sample per program cycle.
        st <= next_st;
        pu <= next_pu;
      end
    end

    // The trip timer keeps its count through a release, as an interrupted fault resumes.
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        el <= 21'h0;
        rc <= 21'h0;
      end else begin
        if (st == ST_NORMAL || st == ST_BLOCKED) begin
          el <= 21'h0;
        end else if (ms_tick && st == ST_START && el < 21'(TIME_MAX_MS)) begin
          el <= el + 21'h1;
        end
        if (st != ST_RELEASE) begin
          rc <= 21'h0;
        end else if (ms_tick && rc < 21'(TIME_MAX_MS)) begin
          rc <= rc + 21'h1;
        end
      end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        cond[s] <= COND_NORMAL;
        {blocked_out[s], trip_out[s], start_out[s]} <= 3'h0;
        ratio[s] <= 24'h0;
        time_left[s] <= 20'sh0;
        time_expected[s] <= 20'h0;
        events[s] <= '0;
        pf <= 32'h0;
        for (int k = 0; k < 3; k++) begin
          counts[s][k] <= 16'h0;
        end
        for (int k = 0; k < HIST_LEN; k++) begin
          hist[k] <= 32'h0;
        end
      end else begin
        cond[s] <= fl[2] ? COND_BLOCKED : fl[1] ? COND_TRIP : fl[0] ? COND_START : COND_NORMAL;
        {blocked_out[s], trip_out[s], start_out[s]} <= fl;
        ratio[s] <= rt > 48'(RATIO_MAX) ? 24'(RATIO_MAX) : rt[23:0];
        time_left[s] <= (st == ST_START) ? 20'(rem / 22'sd5) : 20'sh0;
        time_expected[s] <= 20'(ot / 21'(TIME_STEP_MS));
        events[s].flags <= {off[2], on[2], off[1], on[1], off[0], on[0]} & cfg[s].ev_sel;
        events[s].stamp <= stamp;
        for (int k = 0; k < 3; k++) begin
          // A new occurrence in the clearing cycle is kept as the first count.
          counts[s][k] <= count_clear[s] ? 16'(on[k]) : counts[s][k] + 16'(on[k]);
        end
        if (on[0]) begin
          pf <= hist[HIST_LEN-1];
        end
        if (hist_tick) begin
          hist[0] <= mx;
          for (int k = 1; k < HIST_LEN; k++) begin
            hist[k] <= hist[k-1];
          end
        end
      end
    end

    assign on_ev[s] = on;
    assign mx_a[s] = mx;
    assign fmask_a[s] = (cfg[s].in_sel == IN_PHASES) ? over[2:0] : {2'b00, |over[4:3]};
    assign pretrig_a[s] = hist[0];
    assign prefault_a[s] = on[0] ? hist[HIST_LEN-1] : pf;
    assign remain_a[s] = rem > 22'sd0 ? rem[20:0] : 21'h0;
  end

  hos_rec_t log_mem [N_LOG];
  hos_rec_t new_rec;
  logic [3:0] wptr;
  logic hit;

  // Lowest stage wins when several stages raise an on event together.
  always_comb begin
    hit = 1'b0;
    new_rec = '0;
    for (int s = N_STG - 1; s >= 0; s--) begin
      if (|on_ev[s]) begin
        hit = 1'b1;
        new_rec.stamp = stamp;
        new_rec.stage = 2'(s);
        new_rec.event_code = on_ev[s][0] ? COND_START : on_ev[s][1] ? COND_TRIP : COND_BLOCKED;
        new_rec.fault = fmask_a[s];
        new_rec.pre_trig = pretrig_a[s];
        new_rec.fault_cur = mx_a[s];
        new_rec.pre_fault = prefault_a[s];
        new_rec.remain_ms = remain_a[s];
        new_rec.group = setting_group;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wptr <= 4'h0;
      log_newest <= 4'h0;
      log_count <= 5'h0;
      log_rec <= '0;
      for (int k = 0; k < N_LOG; k++) begin
        log_mem[k] <= '0;
      end
    end else begin
      if (hit) begin
        log_mem[wptr] <= new_rec;
        wptr <= (wptr == 4'(N_LOG - 1)) ? 4'h0 : wptr + 4'h1;
        log_newest <= wptr;
        log_count <= (log_count == 5'(N_LOG)) ? log_count : log_count + 5'h1;
      end
      log_rec <= (5'(log_sel) < 5'(N_LOG)) ? log_mem[log_sel] : '0;
    end
  end

endmodule

// [testbench/hos_props.sv]
// Assertion checker bound to the harmonic overcurrent stage.
`timescale 1ns/1ps
module hos_props
  import hos_pkg::*;
#(
  parameter int N_STG = STAGES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cycle_tick,
  input wire hos_cfg_t cfg [N_STG],
  input wire logic [N_STG-1:0] block_in,
  input wire logic force_enable,
  input wire logic [1:0] cond [N_STG],
  input wire logic [N_STG-1:0] start_out,
  input wire logic [N_STG-1:0] trip_out,
  input wire logic [N_STG-1:0] blocked_out,
  input wire hos_evt_t events [N_STG]
);
  // Forcing sets the state without pick-up, blocking or a prior start, so the checks gated by frc are judged only before it is first used.
  logic frc;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frc <= 1'h0;
    end else if (force_enable) begin
      frc <= 1'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_one_state: assert property ($onehot0({start_out[0], trip_out[0], blocked_out[0]}))
    else $error("state outputs overlap");
  a_cond_start: assert property (start_out[0] |-> cond[0] == COND_START)
    else $error("condition differs from start");
  a_start_tick: assert property (!frc && $rose(start_out[0]) |-> $past(cycle_tick, 2) && !$past(block_in[0], 2))
    else $error("start without unblocked tick");
  a_block_tick: assert property (!frc && $rose(blocked_out[0]) |-> $past(cycle_tick, 2) && $past(block_in[0], 2))
    else $error("blocked without blocking tick");
  a_trip_start: assert property (!frc && $rose(trip_out[0]) |-> $past(start_out[0]) && $past(cycle_tick, 2))
    else $error("trip not preceded by start");
  a_late_block: assert property (!frc && start_out[0] && cycle_tick && block_in[0] |-> ##2 !start_out[0])
    else $error("start survives blocking");
  a_evt_start: assert property (!frc |-> events[0].flags[0] == ($rose(start_out[0]) && $past(cfg[0].ev_sel[0])))
    else $error("start on event wrong");
  a_evt_trip: assert property (!frc |-> events[0].flags[2] == ($rose(trip_out[0]) && $past(cfg[0].ev_sel[2])))
    else $error("trip on event wrong");
  c_start: cover property ($rose(start_out[0]));
  c_trip: cover property ($rose(trip_out[0]));
  c_blocked: cover property ($rose(blocked_out[0]));
endmodule

bind hos_harmonic_overcurrent_stage hos_props #(.N_STG(N_STG)) hos_props_inst (.ref_clk, .resetn, .cycle_tick,
  .cfg, .block_in, .force_enable, .cond, .start_out, .trip_out, .blocked_out, .events);

// [testbench/hos_front_end.sv]
// Behavioural current front end and blocking matrix facing the stage.
`timescale 1ns/1ps
module hos_front_end
  import hos_pkg::*;
(
  input wire logic [2:0] ch,
  input wire logic [3:0] hx,
  input wire logic [15:0] amp,
  input wire logic [15:0] fund,
  input wire logic [3:0] blk,
  output logic [15:0] fft_mag [CHANS][HARMS+1],
  output logic [3:0] block_in
);
  // One harmonic of one channel carries the fault, so a pick-up can only come from that place.
  always_comb begin
    for (int i = 0; i < CHANS; i++) begin
      for (int k = 0; k <= HARMS; k++) begin
        fft_mag[i][k] = k == 0 ? fund : (i == int'(ch) && k == int'(hx) + 1) ? amp : 16'h0000;
      end
    end
  end
  assign block_in = blk;
endmodule

// [testbench/hos_harmonic_overcurrent_stage_tb.sv]
// Self-checking bench for the harmonic overcurrent stage.
`timescale 1ns/1ps
module hos_harmonic_overcurrent_stage_tb import hos_pkg::*;;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic cycle_tick = 1'h0;
  logic force_enable = 1'h0;
  logic [2:0] ch = 3'h0;
  logic [2:0] setting_group = 3'h0;
  logic [3:0] hx = 4'h0;
  logic [3:0] blk = 4'h0;
  logic [3:0] count_clear = 4'h0;
  logic [3:0] log_sel = 4'h0;
  logic [15:0] amp = 16'h0000;
  logic [15:0] fund = 16'h0064;
  logic [15:0] fft_mag [CHANS][HARMS+1];
  logic [15:0] counts [4][3];
  logic [3:0] block_in, start_out, trip_out, blocked_out, log_newest;
  logic [1:0] cond [4];
  logic [23:0] ratio [4];
  logic [19:0] time_expected [4];
  logic signed [19:0] time_left [4];
  logic [4:0] log_count;
  hos_cfg_t c;
  hos_cfg_t cfg [4];
  hos_evt_t events [4];
  hos_rec_t log_rec;
  int seed = 17;
  int n_errors = 0;
  int n_checks = 0;
  int tc = 0;
  int n;
  wire logic [2:0] st = {start_out[0], trip_out[0], blocked_out[0]};
  always_comb cfg = '{c, c, c, c};
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    tc <= (tc + 1) % 5;
    cycle_tick <= tc == 4;
  end
  hos_front_end hos_front_end_inst (.ch, .hx, .amp, .fund, .blk, .fft_mag, .block_in);
  hos_harmonic_overcurrent_stage #(.MS_CYC(10)) hos_harmonic_overcurrent_stage_inst (.ref_clk, .resetn,
    .cycle_tick, .fft_mag, .cfg, .block_in, .force_enable, .setting_group, .count_clear, .log_sel, .cond,
    .start_out, .trip_out, .blocked_out, .ratio, .time_left, .time_expected, .counts, .events, .log_rec,
    .log_newest, .log_count);
  function automatic logic [19:0] xt(input int d, input int t, input int a);
    return 20'(d * t / (a - t) / TIME_STEP_MS);
  endfunction
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic ws(input logic [2:0] e, input string m);
    for (int i = 0; i < 60 && st !== e; i++) begin
      @(negedge ref_clk);
    end
    chk(st === e && cond[0] === (e[2] ? COND_START : e[1] ? COND_TRIP : {2{e[0]}}), m);
    if (st !== e) begin
      end_of_test();
    end
  endtask
  task automatic hold(input logic [2:0] e, input string m);
    repeat (20) @(negedge ref_clk);
    chk(st === e, m);
  endtask
  initial begin
    c = {$bits(hos_cfg_t){1'h0}};
    c.thr_pu = 16'h0064;
    c.thr_pct = 16'h07d0;
    c.delay_ms = 21'h0003e8;
    repeat (10) @(negedge ref_clk);
    resetn = 1'h1;
    @(negedge ref_clk);
    chk(st === 3'h0 && counts[0][0] === 16'h0000 && log_count === 5'h00, "reset");
    for (int h = 0; h < 12; h++) begin
      c.harm_sel = 4'(h);
      c.in_sel = 2'(h % 3);
      c.ev_sel = 6'($random(seed));
      c.force_to = 2'($random(seed));
      setting_group = 3'($random(seed));
      n = h % 3 == 0 ? {$random(seed)} % 3 : h % 3 + 2;
      amp = 16'(101 + {$random(seed)} % 100);
      {ch, hx} = h[0] ? {3'(n > 2 ? 0 : 3), 4'(h)} : {3'(n), 4'((h + 1) % 12)};
      hold(3'h0, "foreign input");
      {ch, hx} = {3'(n), 4'(h)};
      ws(3'h4, "selected pick-up");
      chk(counts[0][0] === 16'(h + 1), "start count");
      amp = 16'h0000;
      ws(3'h0, "release");
    end
    chk(log_count === 5'h0c, "log fill");
    log_sel = log_newest;
    count_clear = 4'hf;
    repeat (2) @(negedge ref_clk);
    chk(log_rec.stage === 2'h0 && log_rec.group === setting_group, "log record");
    chk(counts[0][0] === 16'h0000, "count clear");
    count_clear = 4'h0;
    {c.harm_sel, c.in_sel, ch, hx, c.delay_ms} = {13'h0000, 21'h00000a};
    amp = 16'h0064;
    hold(3'h0, "at threshold");
    amp = 16'h0065;
    ws(3'h4, "above threshold");
    amp = 16'h0061;
    hold(3'h4, "reset band");
    amp = 16'h0060;
    ws(3'h0, "below band");
    amp = 16'h0096;
    ws(3'h4, "pick-up");
    c.thr_pu = 16'h00c8;
    ws(3'h0, "live threshold");
    c.thr_pu = 16'h0064;
    ws(3'h4, "pick-up");
    blk = 4'h1;
    ws(3'h1, "late block");
    repeat (150) @(negedge ref_clk);
    chk(st === 3'h1 && trip_out === 4'he && blocked_out === 4'h1, "blocked holds");
    {amp, blk} = 20'h00000;
    ws(3'h0, "clear");
    {amp, blk} = {16'h0096, 4'h1};
    ws(3'h1, "blocked pick-up");
    blk = 4'h0;
    ws(3'h4, "start");
    chk(ratio[0] === 24'h000096 && time_expected[0] === 20'h00002, "ratio");
    chk(time_left[0] inside {20'sh1, 20'sh2}, "time left");
    n = 0;
    while (trip_out[0] !== 1'h1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n > 85 && n < 115, "fixed delay");
    if (n == 200) begin
      end_of_test();
    end
    amp = 16'h0000;
    ws(3'h0, "clear");
    c.inverse_delay_mode = 1'h1;
    amp = 16'h0096;
    ws(3'h4, "start");
    chk(time_expected[0] === xt(10, 100, 150), "inverse time");
    amp = 16'h0000;
    ws(3'h0, "clear");
    {c.inverse_delay_mode, c.pct_mode, fund, amp} = {2'h1, 16'h00c8, 16'h0015};
    hold(3'h0, "large fundamental");
    fund = 16'h0064;
    ws(3'h4, "percent pick-up");
    amp = 16'h0013;
    ws(3'h0, "percent release");
    force_enable = 1'h1;
    for (int k = 0; k < 4; k++) begin
      c.force_to = 2'(k);
      repeat (8) @(negedge ref_clk);
      chk(cond[0] === 2'(k), "forced state");
    end
    end_of_test();
  end
endmodule
